//--- logic/sss_defines.svh
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH
// ==========================================
// Opcode match patterns
`define OPC_BYTE_STATIC   9'h0ec
`define OPC_WORD_POINTER  4'ha
`define OPC_WORD_STACK    3'h6
`define OPC_HALF_STACK    6'h19
`define OPC_BYTE_STACK    6'h18
`define OPC_SUB_REG       6'h00
`define OPC_SUB_IMM       6'h03
// ==========================================
// Register numbering
`define LOCAL_BASE_IDX    5'h10
`define STACK_PTR_IDX     5'h0e
`define STORE_SRC_IDX     5'h00
// ==========================================
// Flag bit positions within the flag vector
`define FLAG_N            3
`define FLAG_V            2
`define FLAG_Z            1
`define FLAG_C            0
`define FLAGS_RESET       4'h0
`endif

//--- logic/sss_pkg.sv
package sss_pkg;
  // ==========================================
  // Decoded operation kinds
  typedef enum logic [8:0] {
    OP_NONE       = 9'h001,
    OP_BYTE_STAT  = 9'h002,
    OP_WORD_PTR   = 9'h004,
    OP_WORD_STK   = 9'h008,
    OP_HALF_STK   = 9'h010,
    OP_BYTE_STK   = 9'h020,
    OP_SUB_REG    = 9'h040,
    OP_SUB_IMM    = 9'h080,
    OP_SWAP       = 9'h100
  } op_kind_t;
endpackage

//--- logic/sss_decode.sv
`timescale 1ns/1ps
`include "sss_defines.svh"
// Pure decoder: instruction word to operation kind
module sss_decode #(
  parameter int SWAP_OPC = 16'h7d00
) (
  // Instruction
  input  wire logic [15:0]     instr,
  // Decoded kind
  output sss_pkg::op_kind_t    kind
);
  initial begin
    if (SWAP_OPC[4:0] != 0) $error("swap opcode low field must be zero");
  end

  // ==========================================
  // Pattern match in fixed order, static byte store and swap first
  always_comb begin
    kind = sss_pkg::OP_NONE;
    if (instr[15:7] == `OPC_BYTE_STATIC) begin
      kind = sss_pkg::OP_BYTE_STAT;
    end else if (instr[15:5] == SWAP_OPC[15:5]) begin
      kind = sss_pkg::OP_SWAP;
    end else if (instr[15:12] == `OPC_WORD_POINTER) begin
      kind = sss_pkg::OP_WORD_PTR;
    end else if (instr[15:13] == `OPC_WORD_STACK) begin
      kind = sss_pkg::OP_WORD_STK;
    end else if (instr[15:10] == `OPC_HALF_STACK && !instr[0]) begin
      kind = sss_pkg::OP_HALF_STK;
    end else if (instr[15:10] == `OPC_BYTE_STACK) begin
      kind = sss_pkg::OP_BYTE_STK;
    end else if (instr[15:10] == `OPC_SUB_REG) begin
      kind = sss_pkg::OP_SUB_REG;
    end else if (instr[15:10] == `OPC_SUB_IMM) begin
      kind = sss_pkg::OP_SUB_IMM;
    end
  end
endmodule

//--- logic/sss_subtract.sv
`timescale 1ns/1ps
`include "sss_defines.svh"
// Subtractor with condition flags
module sss_subtract (
  // Operands
  input  wire logic [31:0] minuend,
  input  wire logic [31:0] subtrahend,
  // Result and flags
  output logic      [31:0] diff,
  output logic      [3:0]  flags
);
  logic [32:0] wide;

  // ==========================================
  // Carry is the borrow itself, bit 32 of a 33-bit difference
  always_comb begin
    wide = {1'b0, minuend} - {1'b0, subtrahend};
    diff = wide[31:0];
    flags[`FLAG_N] = wide[31];
    flags[`FLAG_V] = (minuend[31] != subtrahend[31]) && (wide[31] != minuend[31]);
    flags[`FLAG_Z] = (wide[31:0] == 32'h0000_0000);
    flags[`FLAG_C] = wide[32];
  end
endmodule

//--- logic/store_subtract_swap_exec.sv
`timescale 1ns/1ps
`include "sss_defines.svh"

// Behaviour
// - Byte store static: base bits 31-2 plus field
// - Static field picks byte of source register
// - Static byte store opcode 011101100 decode
// - Pointer store: aligned base plus field times four
// - Prefixed pointer offset sign-extended, scaled by four
// - Pointer store opcode 1010, base from local 16 to 19 by bits 11-10
// - Stack word store: aligned stack plus field*4
// - Stack word store opcode 110 decode
// - Stack half store: stack plus field*2
// - Stack half store opcode 011001, bit0 clear
// - Stack byte store: stack plus ten-bit field
// - Stack byte store opcode 011000 decode
// - Register subtract writes first minus second
// - Subtract sets N V Z C flags
// - Immediate subtract zero-extends prefix and literal
// - Immediate subtract opcode 000011 decode
// - Swap exchanges register halves, writes back
module store_subtract_swap_exec (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // Instruction issue
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR,
  input  wire logic        PREFIX_VALID,
  input  wire logic [10:0] PREFIX_K,
  // Register file read ports
  output logic      [4:0]  RD_A_IDX,
  output logic      [4:0]  RD_B_IDX,
  input  wire logic [31:0] RD_A_DATA,
  input  wire logic [31:0] RD_B_DATA,
  // Register write-back
  output logic             WB_EN,
  output logic      [4:0]  WB_IDX,
  output logic      [31:0] WB_DATA,
  // Condition flags N V Z C
  output logic      [3:0]  FLAGS,
  // Data memory write
  output logic             MEM_WR,
  output logic      [31:0] MEM_ADDR,
  output logic      [31:0] MEM_WDATA,
  output logic      [3:0]  MEM_BE
);
  // ==========================================
  // State: one packed struct, registered once
  typedef struct packed {
    logic        wb_en;
    logic [4:0]  wb_idx;
    logic [31:0] wb_data;
    logic [3:0]  flags;
    logic        mem_wr;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [3:0]  mem_be;
  } state_t;

  state_t st_reg;
  state_t st_next;

  sss_pkg::op_kind_t kind;
  logic [31:0]       sub_b;
  logic [31:0]       sub_diff;
  logic [3:0]        sub_flags;

  // Byte lane enable for a byte select
  function automatic logic [3:0] byte_lane(input logic [1:0] sel);
    byte_lane = 4'h1 << sel;
  endfunction

  // Word-align a base address
  function automatic logic [31:0] align_word(input logic [31:0] a);
    align_word = {a[31:2], 2'b00};
  endfunction

  // ==========================================
  // Decoder and subtractor
  sss_decode u_decode (
    .instr (INSTR),
    .kind  (kind)
  );

  sss_subtract u_sub (
    .minuend    (RD_A_DATA),
    .subtrahend (sub_b),
    .diff       (sub_diff),
    .flags      (sub_flags)
  );

  // ==========================================
  // Register read selection by operation
  always_comb begin
    RD_A_IDX = INSTR[4:0];
    RD_B_IDX = INSTR[9:5];
    case (kind)
      sss_pkg::OP_BYTE_STAT: RD_B_IDX = `STORE_SRC_IDX;
      sss_pkg::OP_WORD_PTR:  RD_B_IDX = `LOCAL_BASE_IDX | {3'b000, INSTR[11:10]};
      sss_pkg::OP_WORD_STK:  RD_B_IDX = `STACK_PTR_IDX;
      sss_pkg::OP_HALF_STK: begin
        RD_A_IDX = `STORE_SRC_IDX;
        RD_B_IDX = `STACK_PTR_IDX;
      end
      sss_pkg::OP_BYTE_STK: begin
        RD_A_IDX = `STORE_SRC_IDX;
        RD_B_IDX = `STACK_PTR_IDX;
      end
      default: ;
    endcase
  end

  // Second subtract operand: register or zero-extended literal
  always_comb begin
    if (kind == sss_pkg::OP_SUB_IMM) begin
      sub_b = {16'h0000, (PREFIX_VALID ? PREFIX_K : 11'h000), INSTR[9:5]};
    end else begin
      sub_b = RD_B_DATA;
    end
  end

  // ==========================================
  // Next state: one cycle per accepted instruction
  always_comb begin
    logic [15:0] pfx_off;
    logic [31:0] ea;
    pfx_off = {PREFIX_K, INSTR[9:5]};
    ea      = 32'h0000_0000;
    st_next = st_reg;
    st_next.wb_en  = 1'b0;
    st_next.mem_wr = 1'b0;
    if (INSTR_VALID) begin
      case (kind)
        sss_pkg::OP_BYTE_STAT: begin
          // Prefix adds a signed word offset; low base bits dropped either way
          ea = align_word(RD_A_DATA);
          if (PREFIX_VALID) begin
            ea = ea + {{19{PREFIX_K[10]}}, PREFIX_K, 2'b00};
          end
          st_next.mem_wr    = 1'b1;
          st_next.mem_addr  = ea + {30'h0, INSTR[6:5]};
          st_next.mem_wdata = RD_B_DATA;
          st_next.mem_be    = byte_lane(INSTR[6:5]);
        end
        sss_pkg::OP_WORD_PTR: begin
          if (PREFIX_VALID) begin
            ea = align_word(RD_B_DATA) + {{14{pfx_off[15]}}, pfx_off, 2'b00};
          end else begin
            ea = align_word(RD_B_DATA) + {25'h0, INSTR[9:5], 2'b00};
          end
          st_next.mem_wr    = 1'b1;
          st_next.mem_addr  = ea;
          st_next.mem_wdata = RD_A_DATA;
          st_next.mem_be    = 4'hf;
        end
        sss_pkg::OP_WORD_STK: begin
          st_next.mem_wr    = 1'b1;
          st_next.mem_addr  = align_word(RD_B_DATA) + {22'h0, INSTR[12:5], 2'b00};
          st_next.mem_wdata = RD_A_DATA;
          st_next.mem_be    = 4'hf;
        end
        sss_pkg::OP_HALF_STK: begin
          ea = RD_B_DATA + {22'h0, INSTR[9:1], 1'b0};
          st_next.mem_wr    = 1'b1;
          st_next.mem_addr  = ea;
          st_next.mem_wdata = RD_A_DATA;
          st_next.mem_be    = INSTR[1] ? 4'hc : 4'h3;
        end
        sss_pkg::OP_BYTE_STK: begin
          st_next.mem_wr    = 1'b1;
          st_next.mem_addr  = RD_B_DATA + {22'h0, INSTR[9:0]};
          st_next.mem_wdata = RD_A_DATA;
          st_next.mem_be    = byte_lane(INSTR[1:0]);
        end
        sss_pkg::OP_SUB_REG, sss_pkg::OP_SUB_IMM: begin
          st_next.wb_en   = 1'b1;
          st_next.wb_idx  = INSTR[4:0];
          st_next.wb_data = sub_diff;
          st_next.flags   = sub_flags;
        end
        sss_pkg::OP_SWAP: begin
          st_next.wb_en   = 1'b1;
          st_next.wb_idx  = INSTR[4:0];
          st_next.wb_data = {RD_A_DATA[15:0], RD_A_DATA[31:16]};
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Register the state; flags untouched unless subtracting
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_reg <= '0;
      st_reg.flags <= `FLAGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign WB_EN     = st_reg.wb_en;
  assign WB_IDX    = st_reg.wb_idx;
  assign WB_DATA   = st_reg.wb_data;
  assign FLAGS     = st_reg.flags;
  assign MEM_WR    = st_reg.mem_wr;
  assign MEM_ADDR  = st_reg.mem_addr;
  assign MEM_WDATA = st_reg.mem_wdata;
  assign MEM_BE    = st_reg.mem_be;

  // ==========================================
  // Checks
  a_static_byte_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STAT && !PREFIX_VALID) |=>
      MEM_ADDR == {$past(RD_A_DATA[31:2]), $past(INSTR[6:5])})
    else $error("static byte store address wrong");
  a_static_byte_lane: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STAT) |=> MEM_BE == (4'h1 << $past(INSTR[6:5])))
    else $error("static byte lane wrong");
  a_ptr_word_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_WORD_PTR && !PREFIX_VALID) |=>
      MEM_ADDR[1:0] == 2'b00 && MEM_BE == 4'hf && MEM_WR)
    else $error("pointer word store not aligned");
  a_stack_word: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_WORD_STK) |=>
      MEM_ADDR == {$past(RD_B_DATA[31:2]), 2'b00} + {22'h0, $past(INSTR[12:5]), 2'b00})
    else $error("stack word address wrong");
  a_half_lane: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_HALF_STK) |=> MEM_BE == ($past(INSTR[1]) ? 4'hc : 4'h3))
    else $error("half-word lane wrong");
  a_stack_byte: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STK) |=>
      MEM_ADDR == $past(RD_B_DATA) + {22'h0, $past(INSTR[9:0])})
    else $error("stack byte address wrong");
  a_sub_zero: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_SUB_REG && RD_A_DATA == RD_B_DATA) |=>
      FLAGS[`FLAG_Z] && !FLAGS[`FLAG_C] && WB_DATA == 32'h0)
    else $error("equal subtract flags wrong");
  a_flags_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && (kind == sss_pkg::OP_SWAP || kind == sss_pkg::OP_WORD_STK)) |=>
      $stable(FLAGS))
    else $error("flags changed by store or swap");
  a_swap_halves: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_SWAP) |=>
      WB_EN && WB_DATA == {$past(RD_A_DATA[15:0]), $past(RD_A_DATA[31:16])})
    else $error("swap result wrong");
  c_sub_imm: cover property (@(posedge CLOCK) INSTR_VALID && kind == sss_pkg::OP_SUB_IMM);
  c_ptr_pfx: cover property (@(posedge CLOCK)
    INSTR_VALID && kind == sss_pkg::OP_WORD_PTR && PREFIX_VALID);
  c_byte_stk: cover property (@(posedge CLOCK) INSTR_VALID && kind == sss_pkg::OP_BYTE_STK);
  c_half_stk: cover property (@(posedge CLOCK) INSTR_VALID && kind == sss_pkg::OP_HALF_STK);
  c_swap: cover property (@(posedge CLOCK) INSTR_VALID && kind == sss_pkg::OP_SWAP);

  // ==========================================
  // Decode checks, valid bit or not: a pattern must never fall to another kind
  a_dec_byte_stat: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:7] == `OPC_BYTE_STATIC) |-> kind == sss_pkg::OP_BYTE_STAT)
    else $error("static byte store pattern not decoded");
  a_dec_word_ptr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:12] == `OPC_WORD_POINTER) |-> kind == sss_pkg::OP_WORD_PTR)
    else $error("pointer word store pattern not decoded");
  a_dec_word_stk: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:13] == `OPC_WORD_STACK) |-> kind == sss_pkg::OP_WORD_STK)
    else $error("stack word store pattern not decoded");
  a_dec_half_stk: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:10] == `OPC_HALF_STACK) |-> ((kind == sss_pkg::OP_HALF_STK) == !INSTR[0]))
    else $error("half store pattern or its bit 0 misdecoded");
  a_dec_byte_stk: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:10] == `OPC_BYTE_STACK) |-> kind == sss_pkg::OP_BYTE_STK)
    else $error("stack byte store pattern not decoded");
  a_dec_sub_reg: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:10] == `OPC_SUB_REG) |-> kind == sss_pkg::OP_SUB_REG)
    else $error("register subtract pattern not decoded");
  a_dec_sub_imm: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR[15:10] == `OPC_SUB_IMM) |-> kind == sss_pkg::OP_SUB_IMM)
    else $error("immediate subtract pattern not decoded");

  // ==========================================
  // Read steering: stack forms read the stack pointer; half and byte forms also read register zero
  a_ptr_base_idx: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_WORD_PTR) |-> RD_B_IDX == {3'h4, INSTR[11:10]})
    else $error("pointer base register not from the local group");
  a_stack_ptr_idx: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind inside {sss_pkg::OP_WORD_STK, sss_pkg::OP_HALF_STK,
      sss_pkg::OP_BYTE_STK}) |-> RD_B_IDX == `STACK_PTR_IDX)
    else $error("stack store does not read the stack pointer");
  a_stack_src_idx: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind inside {sss_pkg::OP_HALF_STK, sss_pkg::OP_BYTE_STK}) |->
      RD_A_IDX == `STORE_SRC_IDX)
    else $error("stack part store does not read register zero");
  a_static_src_idx: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STAT) |->
      RD_B_IDX == `STORE_SRC_IDX && RD_A_IDX == INSTR[4:0])
    else $error("static byte store reads wrong registers");

  // ==========================================
  // Store checks: whole address and data one cycle after issue
  a_ptr_full_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_WORD_PTR && !PREFIX_VALID) |=>
      MEM_ADDR == {$past(RD_B_DATA[31:2]), 2'b00} + {25'h0, $past(INSTR[9:5]), 2'b00})
    else $error("pointer word store address wrong");
  a_ptr_pfx_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_WORD_PTR && PREFIX_VALID) |=>
      MEM_ADDR == {$past(RD_B_DATA[31:2]), 2'b00} +
        {{14{$past(PREFIX_K[10])}}, $past(PREFIX_K), $past(INSTR[9:5]), 2'b00})
    else $error("prefixed pointer word store address wrong");
  a_word_store_data: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind inside {sss_pkg::OP_WORD_PTR, sss_pkg::OP_WORD_STK}) |=>
      MEM_WR && MEM_WDATA == $past(RD_A_DATA))
    else $error("word store data wrong");
  a_half_addr: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_HALF_STK) |=>
      MEM_WR && MEM_ADDR == $past(RD_B_DATA) + {22'h0, $past(INSTR[9:1]), 1'b0})
    else $error("half store address wrong");
  a_byte_stk_lane: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STK) |=>
      MEM_WR && MEM_BE == (4'h1 << $past(INSTR[1:0])))
    else $error("stack byte lane wrong");
  a_static_byte_data: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_BYTE_STAT) |=>
      MEM_WR && MEM_WDATA == $past(RD_B_DATA))
    else $error("static byte store data wrong");

  // ==========================================
  // Subtract checks; a borrow shows as carry set
  a_sub_reg_result: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_SUB_REG) |=>
      WB_EN && WB_IDX == $past(INSTR[4:0]) && WB_DATA == $past(RD_A_DATA) - $past(RD_B_DATA))
    else $error("register subtract result wrong");
  a_sub_imm_result: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_SUB_IMM) |=>
      WB_EN && WB_DATA == $past(RD_A_DATA) -
        {16'h0000, ($past(PREFIX_VALID) ? $past(PREFIX_K) : 11'h000), $past(INSTR[9:5])})
    else $error("immediate subtract result wrong");
  a_sub_nz_flags: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind inside {sss_pkg::OP_SUB_REG, sss_pkg::OP_SUB_IMM}) |=>
      FLAGS[`FLAG_N] == WB_DATA[31] && FLAGS[`FLAG_Z] == (WB_DATA == 32'h0000_0000))
    else $error("subtract sign or zero flag wrong");
  a_sub_borrow: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind == sss_pkg::OP_SUB_REG) |=>
      FLAGS[`FLAG_C] == ($past(RD_A_DATA) < $past(RD_B_DATA)))
    else $error("subtract borrow flag wrong");
  a_store_flags_kept: assert property (@(posedge CLOCK) disable iff (RESET)
    (INSTR_VALID && kind inside {sss_pkg::OP_BYTE_STAT, sss_pkg::OP_WORD_PTR,
      sss_pkg::OP_HALF_STK, sss_pkg::OP_BYTE_STK}) |=>
      $stable(FLAGS) && !WB_EN)
    else $error("store changed flags or wrote a register");
endmodule

//--- sim/dmem_model.sv
`timescale 1ns/1ps
// ==========================================
// Data memory seen by the store path
module dmem_model (
  // Clock
  input wire logic        CLOCK,
  // Write port
  input wire logic        wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  be
);
  logic [31:0] mem [0:255];
  // Lane writes only, so unselected bytes keep old data
  always_ff @(posedge CLOCK) begin
    if (wr) begin
      for (int i = 0; i < 4; i++) begin
        if (be[i]) begin
          mem[addr[9:2]][8*i +: 8] <= wdata[8*i +: 8];
        end
      end
    end
  end
endmodule

//--- sim/tb_store_subtract_swap_exec.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the store, subtract and swap slice
module tb_store_subtract_swap_exec;
  logic        CLOCK = 1'b0;
  logic        RESET = 1'b1;
  logic        INSTR_VALID = 1'b0;
  logic        PREFIX_VALID = 1'b0;
  logic [15:0] INSTR = 16'h0;
  logic [10:0] PREFIX_K = 11'h0;
  logic [4:0]  RD_A_IDX, RD_B_IDX, WB_IDX;
  logic        WB_EN, MEM_WR;
  logic [31:0] WB_DATA, MEM_ADDR, MEM_WDATA;
  logic [3:0]  FLAGS, MEM_BE;
  logic [31:0] regs [0:31];
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // Register file answers in the same cycle
  wire  [31:0] RD_A_DATA = regs[RD_A_IDX];
  wire  [31:0] RD_B_DATA = regs[RD_B_IDX];
  always #2.5 CLOCK = ~CLOCK;
  store_subtract_swap_exec u_dut (.CLOCK(CLOCK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .PREFIX_VALID(PREFIX_VALID), .PREFIX_K(PREFIX_K), .RD_A_IDX(RD_A_IDX),
    .RD_B_IDX(RD_B_IDX), .RD_A_DATA(RD_A_DATA), .RD_B_DATA(RD_B_DATA), .WB_EN(WB_EN),
    .WB_IDX(WB_IDX), .WB_DATA(WB_DATA), .FLAGS(FLAGS), .MEM_WR(MEM_WR),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_BE(MEM_BE));
  dmem_model u_mem (.CLOCK(CLOCK), .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA),
    .be(MEM_BE));
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d bad=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well above the sixty or so cycles needed
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [3:0] flg(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] r;
    r = a - b;
    return {r[31], (a[31] != b[31]) && (r[31] != a[31]), r == 32'h0, a < b};
  endfunction
  // One instruction, answer sampled at the following falling edge
  task automatic issue(input logic [15:0] i, input logic p, input logic [10:0] k);
    @(negedge CLOCK);
    INSTR_VALID = 1'b1;
    INSTR = i;
    PREFIX_VALID = p;
    PREFIX_K = k;
    @(negedge CLOCK);
    INSTR_VALID = 1'b0;
  endtask
  task automatic st(input logic [15:0] i, input logic p, input logic [10:0] k,
                    input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [3:0] f;
    f = FLAGS;
    issue(i, p, k);
    chk(MEM_WR, 32'h1);
    chk(WB_EN, 32'h0);
    chk(MEM_ADDR, a);
    chk(MEM_BE, b);
    chk(MEM_WDATA, d);
    chk(FLAGS, f);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_stores();
    for (int n = 0; n < 4; n++) begin
      st({9'h0ec, n[1:0], 5'h05}, 1'b0, 11'h0, {regs[5][31:2], 2'h0} + n, 4'h1 << n,
         regs[0]);
      st({4'ha, n[1:0], 5'h03, 5'h07}, 1'b0, 11'h0, {regs[16+n][31:2], 2'h0} + 32'hc,
         4'hf, regs[7]);
    end
    st(16'ha7e7, 1'b1, 11'h7ff, {regs[17][31:2], 2'h0} - 32'h4, 4'hf, regs[7]);
    st(16'ha407, 1'b1, 11'h001, {regs[17][31:2], 2'h0} + 32'h80, 4'hf, regs[7]);
    st(16'h7665, 1'b1, 11'h7ff, {regs[5][31:2], 2'h0} - 32'h1, 4'h8, regs[0]);
    st({3'h6, 8'hff, 5'h07}, 1'b0, 11'h0, 32'h7fc, 4'hf, regs[7]);
    @(negedge CLOCK);
    chk(u_mem.mem[8'hff], regs[7]);
    st({3'h6, 8'h00, 5'h08}, 1'b0, 11'h0, 32'h400, 4'hf, regs[8]);
  endtask
  task automatic t_stack_parts();
    logic [8:0] h [3] = '{9'h000, 9'h001, 9'h1ff};
    logic [9:0] v [5] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h3ff};
    for (int n = 0; n < 3; n++) begin
      st({6'h19, h[n], 1'b0}, 1'b0, 11'h0, regs[14] + {h[n], 1'b0},
         h[n][0] ? 4'hc : 4'h3, regs[0]);
    end
    for (int n = 0; n < 5; n++) begin
      st({6'h18, v[n]}, 1'b0, 11'h0, regs[14] + v[n], 4'h1 << v[n][1:0],
         regs[0]);
    end
  endtask
  task automatic t_sub();
    logic [31:0] xs [4] = '{32'h5, 32'h3, 32'h8000_0000, 32'h7};
    logic [31:0] ys [4] = '{32'h3, 32'h5, 32'h1, 32'h7};
    for (int n = 0; n < 4; n++) begin
      regs[1] = xs[n];
      regs[2] = ys[n];
      issue(16'h0041, 1'b0, 11'h0);
      chk(WB_EN, 32'h1);
      chk(WB_IDX, 32'h1);
      chk(WB_DATA, xs[n] - ys[n]);
      chk(FLAGS, flg(xs[n], ys[n]));
    end
    regs[1] = 32'h5;
    issue(16'h0cc1, 1'b0, 11'h0);
    chk(WB_DATA, 32'hffff_ffff);
    chk(FLAGS, flg(32'h5, 32'h6));
    regs[1] = 32'h1_0000;
    issue(16'h0fe1, 1'b1, 11'h7ff);
    chk(WB_DATA, 32'h1);
    chk(FLAGS, 4'h0);
  endtask
  task automatic t_swap_refuse();
    logic [3:0] f;
    regs[9] = 32'h1234_abcd;
    f = FLAGS;
    issue(16'h7d09, 1'b0, 11'h0);
    chk(WB_EN, 32'h1);
    chk(WB_IDX, 32'h9);
    chk(WB_DATA, 32'habcd_1234);
    chk(FLAGS, f);
    issue(16'h6401, 1'b0, 11'h0);
    chk(MEM_WR, 32'h0);
    chk(WB_EN, 32'h0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    for (int n = 0; n < 32; n++) regs[n] = 32'h1000_0000 + n * 32'h0101_0103;
    regs[0] = 32'h4433_2211;
    regs[14] = 32'h0000_0403;
    repeat (2) @(negedge CLOCK);
    RESET = 1'b0;
    chk(FLAGS, 32'h0);
    chk(MEM_WR, 32'h0);
    t_stores();
    regs[14] = 32'h0000_0400;
    t_stack_parts();
    t_sub();
    t_swap_refuse();
    tally_and_finish();
  end
endmodule
